// ### pkg/bmec_pkg.sv
// Package with register map, reset values, mode states and timing constants for the buck control.
package bmec_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] BMEC_CORE_CTRL_ADDR = 8'h05;
  localparam logic [7:0] BMEC_IO_CTRL_ADDR = 8'h06;
  localparam logic [7:0] BMEC_CORE_CTRL_RESET = 8'h09;
  localparam logic [7:0] BMEC_IO_CTRL_RESET = 8'h5f;
  localparam int BMEC_EN_BIT = 6;
  localparam int BMEC_FPWM_BIT = 5;
  localparam logic [4:0] BMEC_CODE_EXT = 5'h00;
  localparam logic [4:0] BMEC_CODE_TOP = 5'h18;
  localparam logic [7:0] BMEC_WRITE_MASK = 8'h7f;

  // ****************************************************************
  // Output level decode, in units of 10 mV
  // ****************************************************************
  localparam logic [7:0] BMEC_CORE_BASE_10MV = 8'h50;
  localparam logic [7:0] BMEC_CORE_STEP_10MV = 8'h05;
  localparam logic [7:0] BMEC_CORE_MAX_10MV = 8'hc8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int BMEC_LIGHT_LOAD_CYCLES = 32;
  localparam int BMEC_CLK_NS = 8;
  localparam int BMEC_DRAIN_NS = 16;
  localparam int BMEC_DRAIN_CYCLES =
    (BMEC_DRAIN_NS / BMEC_CLK_NS) < 1 ? 1 : (BMEC_DRAIN_NS / BMEC_CLK_NS);

  // ****************************************************************
  // Converter states
  // ****************************************************************
  typedef enum logic [2:0] {
    BMEC_OFF,
    BMEC_PWM,
    BMEC_PFM_HIGH,
    BMEC_PFM_LOW,
    BMEC_PFM_DRAIN,
    BMEC_PFM_SLEEP
  } bmec_state_t;

endpackage

// ### rtl/bmec_top.sv
// Mode, switch sequencing and enable control for the core and io step-down regulators.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enter pulse-frequency mode after 32 cycles discontinuous or below mode current.
// - In pulse-width mode an overcurrent trip ends the high-side pulse that cycle.
// - Pulse-frequency band is set by comparators 0.8 to 1.6 percent above nominal.
// - Pulse mode: high side on until above high threshold or peak limit.
// - After high side, low side conducts until zero current detected.
// - Still below high threshold after low phase: repeat high then low.
// - At high threshold drain briefly on low side, then both off and sleep.
// - Sleeping, output below low threshold restarts the pulse sequence.
// - Below the return threshold in pulse mode, go back to pulse-width mode.
// - Pulse-width mode drives the low side as synchronous rectifier in off time.
// - Voltage code zero selects external feedback divider.
// - Core code 1 is 0.80 V, 50 mV steps to 1.95 V; 19-1F give 2.00 V.
// - Modulation bit 5 clear: automatic mode; set: forced pulse-width.
// - Core enable bit 6 clear: core follows its enable pin.
// - Core enable bit 6 set enables core regardless of pin.
// - Core pin high at power-on turns core on and keeps it on.
// - Io regulator on by default, then controlled only by its bit 6.

// ****************************************************************
// One converter channel
// ****************************************************************
module bmec_channel
  import bmec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic force_pwm,
  input wire logic pwm_on_phase,
  input wire logic discontinuous,
  input wire logic below_mode_current,
  input wire logic overcurrent,
  input wire logic pulse_peak_current_limit,
  input wire logic zero_current,
  input wire logic above_high,
  input wire logic below_low,
  input wire logic below_return,
  output logic high_side_on,
  output logic low_side_on,
  output logic pfm_active
);

  bmec_state_t state;
  bmec_state_t next_state;
  logic [5:0] light_count;
  logic [1:0] drain_count;
  logic light_done;

  // Light-load persistence; any heavy-load cycle restarts the count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      light_count <= 6'h00;
    end else if (state != BMEC_PWM || force_pwm ||
                 !(discontinuous || below_mode_current)) begin
      light_count <= 6'h00;
    end else if (!light_done) begin
      light_count <= light_count + 6'h01;
    end
  end
  assign light_done = (light_count >= 6'(BMEC_LIGHT_LOAD_CYCLES - 1));

  // Drain timer for the short low-side pulse before sleeping.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drain_count <= 2'h0;
    end else if (state == BMEC_PFM_DRAIN) begin
      drain_count <= drain_count + 2'h1;
    end else begin
      drain_count <= 2'h0;
    end
  end

  // Next-state logic; disable overrides every mode condition.
  always_comb begin
    next_state = state;
    if (!enable) begin
      next_state = BMEC_OFF;
    end else begin
      case (state)
        BMEC_OFF: begin
          next_state = BMEC_PWM;
        end
        BMEC_PWM: begin
          if (light_done && (discontinuous || below_mode_current) && !force_pwm) begin
            next_state = BMEC_PFM_HIGH;
          end
        end
        default: begin
          if (force_pwm || below_return) begin
            next_state = BMEC_PWM;
          end else begin
            case (state)
              BMEC_PFM_HIGH: begin
                if (above_high) begin
                  next_state = BMEC_PFM_DRAIN;
                end else if (pulse_peak_current_limit) begin
                  next_state = BMEC_PFM_LOW;
                end
              end
              BMEC_PFM_LOW: begin
                if (zero_current) begin
                  next_state = above_high ? BMEC_PFM_SLEEP : BMEC_PFM_HIGH;
                end
              end
              BMEC_PFM_DRAIN: begin
                if (zero_current || drain_count >= 2'(BMEC_DRAIN_CYCLES - 1)) begin
                  next_state = BMEC_PFM_SLEEP;
                end
              end
              BMEC_PFM_SLEEP: begin
                if (below_low) begin
                  next_state = BMEC_PFM_HIGH;
                end
              end
              default: begin
                next_state = BMEC_OFF;
              end
            endcase
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= BMEC_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Switch drive is registered so both gates never glitch on together.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_side_on <= 1'b0;
      low_side_on <= 1'b0;
      pfm_active <= 1'b0;
    end else begin
      pfm_active <= (next_state != BMEC_OFF) && (next_state != BMEC_PWM);
      case (next_state)
        BMEC_PWM: begin
          high_side_on <= pwm_on_phase && !overcurrent;
          low_side_on <= !(pwm_on_phase && !overcurrent);
        end
        BMEC_PFM_HIGH: begin
          high_side_on <= 1'b1;
          low_side_on <= 1'b0;
        end
        BMEC_PFM_LOW, BMEC_PFM_DRAIN: begin
          high_side_on <= 1'b0;
          low_side_on <= 1'b1;
        end
        default: begin
          high_side_on <= 1'b0;
          low_side_on <= 1'b0;
        end
      endcase
    end
  end

  property p_off_quiet;
    @(posedge clk) disable iff (rst) !enable |=> !high_side_on && !low_side_on;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("switch on while disabled");

  property p_ocp;
    @(posedge clk) disable iff (rst)
      state == BMEC_PWM && next_state == BMEC_PWM && overcurrent |=> !high_side_on;
  endproperty
  a_ocp: assert property (p_ocp) else $error("high side on despite overcurrent");

  property p_no_early_pfm;
    @(posedge clk) disable iff (rst)
      state == BMEC_PWM && light_count < 6'h1f |=> state != BMEC_PFM_HIGH;
  endproperty
  a_no_early_pfm: assert property (p_no_early_pfm) else $error("early pfm entry");

  sequence s_pfm_sleep;
    state == BMEC_PFM_SLEEP && below_low && enable && !force_pwm && !below_return;
  endsequence
  property p_wake;
    @(posedge clk) disable iff (rst) s_pfm_sleep |=> state == BMEC_PFM_HIGH ##0 high_side_on;
  endproperty
  a_wake: assert property (p_wake) else $error("no restart from sleep");

  property p_return;
    @(posedge clk) disable iff (rst) pfm_active && below_return && enable |=> state == BMEC_PWM;
  endproperty
  a_return: assert property (p_return) else $error("no return to pwm");

  property p_force;
    @(posedge clk) disable iff (rst) force_pwm && enable |=> !pfm_active;
  endproperty
  a_force: assert property (p_force) else $error("pfm while forced pwm");

  property p_drain_bound;
    @(posedge clk) disable iff (rst)
      state == BMEC_PFM_DRAIN && enable && !force_pwm && !below_return
      |-> ##[1:2] state != BMEC_PFM_DRAIN;
  endproperty
  a_drain_bound: assert property (p_drain_bound) else $error("drain too long");

  property p_no_overlap;
    @(posedge clk) disable iff (rst) !(high_side_on && low_side_on);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("shoot-through");

endmodule

// ****************************************************************
// Top: register port, enables, code decode and both channels
// ****************************************************************
module bmec_top
  import bmec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic core_regulator_enable_pin,
  input wire logic [1:0] pwm_on_phase,
  input wire logic [1:0] discontinuous,
  input wire logic [1:0] below_mode_current,
  input wire logic [1:0] overcurrent,
  input wire logic [1:0] pulse_peak_current_limit,
  input wire logic [1:0] zero_current,
  input wire logic [1:0] above_high,
  input wire logic [1:0] below_low,
  input wire logic [1:0] return_to_fixed_frequency_threshold,
  output logic [1:0] high_side_on,
  output logic [1:0] low_side_on,
  output logic [1:0] pfm_active,
  output logic [1:0] regulator_enabled,
  output logic [1:0] external_feedback,
  output logic [7:0] core_level_10mv
);

  logic [7:0] core_regulator_control;
  logic [7:0] io_regulator_control;
  logic pin_strap_seen;
  logic pin_latched_on;
  logic [1:0] force_pwm;

  // Register writes; bit 7 is reserved and stays zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_regulator_control <= BMEC_CORE_CTRL_RESET;
      io_regulator_control <= BMEC_IO_CTRL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == BMEC_CORE_CTRL_ADDR) begin
        core_regulator_control <= reg_wdata & BMEC_WRITE_MASK;
      end else if (reg_addr == BMEC_IO_CTRL_ADDR) begin
        io_regulator_control <= reg_wdata & BMEC_WRITE_MASK;
      end
    end
  end

  // Read decode; unmapped addresses read zero.
  always_comb begin
    if (reg_addr == BMEC_CORE_CTRL_ADDR) begin
      reg_rdata = core_regulator_control;
    end else if (reg_addr == BMEC_IO_CTRL_ADDR) begin
      reg_rdata = io_regulator_control;
    end else begin
      reg_rdata = 8'h00;
    end
  end

  // The pin level is caught on the first clock after reset release, not under reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_strap_seen <= 1'b0;
      pin_latched_on <= 1'b0;
    end else if (!pin_strap_seen) begin
      pin_strap_seen <= 1'b1;
      pin_latched_on <= core_regulator_enable_pin;
    end
  end

  // Enables: the core follows the pin unless the bit or power-on strap holds it on.
  always_comb begin
    regulator_enabled[0] = core_regulator_control[BMEC_EN_BIT] ||
                           core_regulator_enable_pin || pin_latched_on;
    regulator_enabled[1] = io_regulator_control[BMEC_EN_BIT];
    force_pwm[0] = core_regulator_control[BMEC_FPWM_BIT];
    force_pwm[1] = io_regulator_control[BMEC_FPWM_BIT];
  end

  // Voltage code decode, registered for a clean reference setting.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      external_feedback <= 2'b00;
      core_level_10mv <= 8'h00;
    end else begin
      external_feedback[0] <= core_regulator_control[4:0] == BMEC_CODE_EXT;
      external_feedback[1] <= io_regulator_control[4:0] == BMEC_CODE_EXT;
      if (core_regulator_control[4:0] == BMEC_CODE_EXT) begin
        core_level_10mv <= 8'h00;
      end else if (core_regulator_control[4:0] > BMEC_CODE_TOP) begin
        core_level_10mv <= BMEC_CORE_MAX_10MV;
      end else begin
        core_level_10mv <= 8'(BMEC_CORE_BASE_10MV +
          BMEC_CORE_STEP_10MV * ({3'b000, core_regulator_control[4:0]} - 8'h01));
      end
    end
  end

  // Two identical channels.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      bmec_channel u_ch (
        .clk(clk),
        .rst(rst),
        .enable(regulator_enabled[ch]),
        .force_pwm(force_pwm[ch]),
        .pwm_on_phase(pwm_on_phase[ch]),
        .discontinuous(discontinuous[ch]),
        .below_mode_current(below_mode_current[ch]),
        .overcurrent(overcurrent[ch]),
        .pulse_peak_current_limit(pulse_peak_current_limit[ch]),
        .zero_current(zero_current[ch]),
        .above_high(above_high[ch]),
        .below_low(below_low[ch]),
        .below_return(return_to_fixed_frequency_threshold[ch]),
        .high_side_on(high_side_on[ch]),
        .low_side_on(low_side_on[ch]),
        .pfm_active(pfm_active[ch])
      );
    end
  endgenerate

  property p_core_bit;
    @(posedge clk) disable iff (rst) core_regulator_control[BMEC_EN_BIT] |-> regulator_enabled[0];
  endproperty
  a_core_bit: assert property (p_core_bit) else $error("core off with bit set");

  property p_core_pin;
    @(posedge clk) disable iff (rst)
      !core_regulator_control[BMEC_EN_BIT] && !pin_latched_on
      |-> regulator_enabled[0] == core_regulator_enable_pin;
  endproperty
  a_core_pin: assert property (p_core_pin) else $error("core does not follow pin");

  property p_io_bit;
    @(posedge clk) disable iff (rst) regulator_enabled[1] == io_regulator_control[BMEC_EN_BIT];
  endproperty
  a_io_bit: assert property (p_io_bit) else $error("io enable mismatch");

  property p_top_code;
    @(posedge clk) disable iff (rst)
      core_regulator_control[4:0] > BMEC_CODE_TOP |=> core_level_10mv == BMEC_CORE_MAX_10MV;
  endproperty
  a_top_code: assert property (p_top_code) else $error("top code not 2.00 V");

  property p_ext_fb;
    @(posedge clk) disable iff (rst)
      core_regulator_control[4:0] == BMEC_CODE_EXT |=> external_feedback[0];
  endproperty
  a_ext_fb: assert property (p_ext_fb) else $error("external feedback not chosen");

endmodule

`default_nettype wire

// ### dv/bmec_stage_model.sv
// Behavioural power stage and feedback comparators for one converter channel.
`timescale 1ns/1ps
`default_nettype none
module bmec_stage_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic light,
  input wire logic heavy,
  output logic discontinuous,
  output logic below_mode_current,
  output logic pulse_peak_current_limit,
  output logic zero_current,
  output logic above_high,
  output logic below_low,
  output logic below_return
);
  int vout;
  int amps;
  // Output rises while the high side conducts; a light load only drains it while both
  // switches are off, a heavy load always. The clamp keeps the level in range.
  always @(posedge clk or posedge rst) begin : stage
    int nv;
    if (rst) begin
      vout <= 105;
      amps <= 0;
    end else begin
      nv = vout + (high_side_on ? 2 : 0);
      nv = nv - (heavy ? 4 : ((high_side_on || low_side_on) ? 0 : 1));
      vout <= (nv < 80) ? 80 : ((nv > 130) ? 130 : nv);
      if (high_side_on) begin
        amps <= amps + 1;
      end else if (low_side_on && amps > 0) begin
        amps <= amps - 1;
      end
    end
  end
  // Comparator outputs derived from the modelled level and current; the two light-load flags follow the light input.
  assign discontinuous = light;
  assign below_mode_current = light;
  assign pulse_peak_current_limit = (amps >= 3);
  assign zero_current = (amps == 0);
  assign above_high = (vout >= 110);
  assign below_low = (vout < 100);
  assign below_return = (vout < 90);
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the buck mode, switch sequencing and enable control.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bmec_pkg::*;
  typedef struct {int sel; logic [7:0] exp;} bmec_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, lvl;
  logic pin = 1'b0;
  logic [1:0] phase = 2'b00, oc = 2'b00, light = 2'b00, heavy = 2'b00;
  logic [1:0] disc, bmc, peak, zc, hi, lo, ret, hs, ls, pfm, en, ext;
  bmec_note_t notes[$];
  int err_count = 0;
  int checked = 0;
  logic [31:0] lfsr = 32'he01042df;
  string names[8] = '{"rdata", "high", "low", "pfm", "enabled", "extfb", "level", "core_gates"};

  always #4 clk = ~clk;

  bmec_top DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .core_regulator_enable_pin(pin),
    .pwm_on_phase(phase), .discontinuous(disc), .below_mode_current(bmc),
    .overcurrent(oc), .pulse_peak_current_limit(peak), .zero_current(zc),
    .above_high(hi), .below_low(lo), .return_to_fixed_frequency_threshold(ret),
    .high_side_on(hs), .low_side_on(ls), .pfm_active(pfm), .regulator_enabled(en),
    .external_feedback(ext), .core_level_10mv(lvl));

  // One stage model per channel.
  bmec_stage_model p0 (.clk(clk), .rst(rst), .high_side_on(hs[0]), .low_side_on(ls[0]),
    .light(light[0]), .heavy(heavy[0]), .discontinuous(disc[0]), .below_mode_current(bmc[0]),
    .pulse_peak_current_limit(peak[0]), .zero_current(zc[0]), .above_high(hi[0]),
    .below_low(lo[0]), .below_return(ret[0]));
  bmec_stage_model p1 (.clk(clk), .rst(rst), .high_side_on(hs[1]), .low_side_on(ls[1]),
    .light(light[1]), .heavy(heavy[1]), .discontinuous(disc[1]), .below_mode_current(bmc[1]),
    .pulse_peak_current_limit(peak[1]), .zero_current(zc[1]), .above_high(hi[1]),
    .below_low(lo[1]), .below_return(ret[1]));

  // Selects the observed output for a note.
  function automatic logic [7:0] obs(input int sel);
    case (sel)
      0: obs = reg_rdata;
      1: obs = {6'h00, hs};
      2: obs = {6'h00, ls};
      3: obs = {6'h00, pfm};
      4: obs = {6'h00, en};
      5: obs = {6'h00, ext};
      6: obs = lvl;
      default: obs = {6'h00, hs[0], ls[0]};
    endcase
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Monitor: settles just after each falling edge, then drains the notes.
  always @(negedge clk) begin
    #1;
    while (notes.size() > 0) begin
      bmec_note_t n;
      n = notes.pop_front();
      checked++;
      if (obs(n.sel) !== n.exp) begin
        err_count++;
        $display("[ERR] %s expected %h seen %h", names[n.sel], n.exp, obs(n.sel));
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Notes an expectation, then holds every input for a cycle, so the monitor sees
  // just after this falling edge the outputs that the note was made for.
  task automatic note(input int sel, input logic [7:0] exp);
    notes.push_back('{sel, exp});
    cyc(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    note(0, exp);
  endtask

  // Bounded wait for an output value; running out ends the run.
  task automatic wait_on(input int sel, input logic [7:0] exp, input int bound);
    int n;
    n = 0;
    while (obs(sel) !== exp && n < bound) begin
      cyc(1);
      n++;
    end
    if (obs(sel) !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", names[sel], exp, obs(sel));
      summarize();
    end
  endtask

  task automatic do_reset();
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] lv;
    do_reset();
    rd(BMEC_CORE_CTRL_ADDR, BMEC_CORE_CTRL_RESET);
    rd(BMEC_IO_CTRL_ADDR, BMEC_IO_CTRL_RESET);
    rd(8'h07, 8'h00);
    note(4, 8'h02);
    $display("test reset done");
    pin = 1'b1;
    cyc(1);
    note(4, 8'h03);
    pin = 1'b0;
    wr(BMEC_CORE_CTRL_ADDR, 8'h49);
    note(4, 8'h03);
    wr(BMEC_IO_CTRL_ADDR, 8'h1f);
    note(4, 8'h01);
    cyc(2);
    note(1, 8'h00);
    note(2, 8'h01);
    $display("test enables done");
    // Every code, with a random bit 7 that must read back as zero.
    for (int c = 0; c < 32; c++) begin
      lfsr = lfsr_next(lfsr);
      wr(BMEC_CORE_CTRL_ADDR, {lfsr[7], 2'b11, c[4:0]});
      cyc(2);
      lv = (c == 0) ? 8'h00 : (c > 8'h18) ? BMEC_CORE_MAX_10MV :
        BMEC_CORE_BASE_10MV + BMEC_CORE_STEP_10MV * 8'(c - 1);
      rd(BMEC_CORE_CTRL_ADDR, {3'b011, c[4:0]});
      note(5, {7'h00, c == 0});
      note(6, lv);
    end
    wr(BMEC_IO_CTRL_ADDR, 8'h60);
    cyc(1);
    note(5, 8'h02);
    wr(BMEC_IO_CTRL_ADDR, 8'h1f);
    $display("test decode done");
    wr(BMEC_CORE_CTRL_ADDR, 8'h69);
    phase[0] = 1'b1;
    cyc(2);
    note(1, 8'h01);
    oc[0] = 1'b1;
    cyc(2);
    note(7, 8'h01);
    oc[0] = 1'b0;
    phase[0] = 1'b0;
    cyc(2);
    note(7, 8'h01);
    light[0] = 1'b1;
    cyc(40);
    note(3, 8'h00);
    $display("test pulse width done");
    light[0] = 1'b0;
    wr(BMEC_CORE_CTRL_ADDR, 8'h49);
    light[0] = 1'b1;
    cyc(31);
    note(3, 8'h00);
    wait_on(3, 8'h01, 4);
    wait_on(7, 8'h00, 100);
    wait_on(7, 8'h02, 100);
    wait_on(7, 8'h01, 20);
    wait_on(7, 8'h02, 20);
    wait_on(7, 8'h00, 100);
    note(3, 8'h01);
    heavy[0] = 1'b1;
    wait_on(3, 8'h00, 200);
    heavy[0] = 1'b0;
    light[0] = 1'b0;
    $display("test pulse frequency done");
    wr(BMEC_CORE_CTRL_ADDR, 8'h09);
    note(4, 8'h00);
    cyc(2);
    note(7, 8'h00);
    pin = 1'b1;
    do_reset();
    cyc(2);
    pin = 1'b0;
    cyc(1);
    note(4, 8'h03);
    $display("test strap done");
    cyc(2);
    summarize();
  end
endmodule
`default_nettype wire
